// File: design/gdsc_params.svh
// Constants of the gate driver sense and overcurrent control block.
`ifndef GDSC_PARAMS_SVH
`define GDSC_PARAMS_SVH

// ****************************************
// Register byte offsets (Wishbone, 32-bit words)
// ****************************************
`define GDSC_OFS_PUMP    8'h00
`define GDSC_OFS_SENSE   8'h04
`define GDSC_OFS_OCP     8'h08
`define GDSC_OFS_STATUS  8'h0c
`define GDSC_OFS_CMD     8'h10

// ****************************************
// Field positions
// ****************************************
`define GDSC_PUMP_FREQ_LO    0
`define GDSC_PUMP_SPREAD     2
`define GDSC_PUMP_PRECHG     3
`define GDSC_SNS_EN_LO       0
`define GDSC_SNS_MODE_LO     3
`define GDSC_SNS_GAIN_LO     5
`define GDSC_SNS_OFS_LO      8
`define GDSC_SNS_BLANK_LO    10
`define GDSC_SNS_AZ_DIS      14
`define GDSC_SNS_GAINSRC     15
`define GDSC_SNS_CAL         16
`define GDSC_OCP_REACT_LO    0
`define GDSC_OCP_BRAKE_LO    2
`define GDSC_OCP_LATCH       4
`define GDSC_OCP_COUNT_LO    5
`define GDSC_CMD_CLEAR       0

// ****************************************
// Reset values
// ****************************************
`define GDSC_RST_PUMP   32'h0000_0004
`define GDSC_RST_SENSE  32'h0000_000f
`define GDSC_RST_OCP    32'h0000_0020

// ****************************************
// Timing (125 MHz clock, 8 ns period)
// ****************************************
`define GDSC_CLK_PERIOD_PS   8000
`define GDSC_PUMP_DIV_781K   80
`define GDSC_BLANK_50NS_PS   50000
`define GDSC_BLANK_8US_PS    8000000
`define GDSC_BLANK_MIN_CYC   ((`GDSC_BLANK_50NS_PS + `GDSC_CLK_PERIOD_PS - 1) / `GDSC_CLK_PERIOD_PS)
`define GDSC_BLANK_MAX_CYC   (`GDSC_BLANK_8US_PS / `GDSC_CLK_PERIOD_PS)
`define GDSC_BLANK_MID1_CYC  25
`define GDSC_BLANK_MID2_CYC  63
`define GDSC_BLANK_MID3_CYC  125
`define GDSC_BLANK_MID4_CYC  250
`define GDSC_BLANK_MID5_CYC  500
`define GDSC_BLANK_MID6_CYC  750
`define GDSC_AZ_TIMEOUT_CYC  125000

`endif

// File: design/gdsc_pkg.sv
// Types of the gate driver sense and overcurrent control block.
package gdsc_pkg;

	// Sense output window modes
	typedef enum logic [1:0] {
		GDSC_MODE_OFF      = 2'b00,
		GDSC_MODE_LOWSIDE  = 2'b01,
		GDSC_MODE_EXTENDED = 2'b10,
		GDSC_MODE_ON       = 2'b11
	} gdsc_mode_t;

	// Overcurrent reaction
	typedef enum logic [1:0] {
		GDSC_REACT_TRUNC_REPORT = 2'b00,
		GDSC_REACT_TRUNC_ONLY   = 2'b01,
		GDSC_REACT_BRAKE        = 2'b10,
		GDSC_REACT_IGNORE       = 2'b11
	} gdsc_react_t;

	// Six PWM or gate signals, one bit per phase
	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
	} gdsc_gates_t;

	// Whole block state
	typedef struct packed {
		logic [31:0] pump_q;
		logic [31:0] sense_q;
		logic [31:0] ocp_q;
		logic ack_q;
		logic [31:0] rdata_q;
		logic [8:0] pump_cnt_q;
		logic pump_clk_q;
		logic [3:0] lfsr_q;
		logic [2:0] hs_prev_q;
		logic [2:0] ls_prev_q;
		logic [2:0] win_prev_q;
		logic [12:0] blank_cnt_q0;
		logic [12:0] blank_cnt_q1;
		logic [12:0] blank_cnt_q2;
		logic [16:0] az_cnt_q;
		logic az_pulse_q;
		logic pwm_prev_q;
		logic oc_in_cycle_q;
		logic [3:0] oc_run_q;
		logic fault_q;
		logic trunc_q;
		logic gain_loaded_q;
		logic [2:0] gain_q;
		logic [2:0] sense_conn_q;
	} gdsc_state_t;

endpackage

// File: design/gdsc_core.sv
// Sense amplifier gating, auto-zero, charge pump clock and overcurrent control.
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "gdsc_params.svh"

// ****************************************
// Register map
// ****************************************
// Pump word:
//   bits 1:0 rate code
//     0 is the default rate
//     1 is half the default rate
//     2 is twice the default rate
//     3 is a quarter of the default rate
//   bit 2 spread spectrum, on after reset
//   bit 3 pre-charge, off after reset
// Sense word:
//   bits 2:0 amplifier enables, one per phase
//   bits 4:3 output window mode
//     0 output always off
//     1 low-side window, the reset mode
//     2 extended window, low side plus dead-times
//     3 output always on
//   bits 7:5 gain code, zero gives the lowest gain
//   bits 9:8 offset code, zero gives half supply
//   bits 12:10 blanking code, zero disables blanking
//   bit 14 auto-zero disable
//   bit 15 gain taken from the external resistor
//   bit 16 user calibration request
// Overcurrent word:
//   bits 1:0 reaction
//     0 truncate and report
//     1 truncate only
//     2 brake instead of truncating
//     3 ignore the event
//   bits 3:2 brake mode, zero leaves the gates alone
//   bit 4 latched fault
//   bits 8:5 consecutive PWM cycle target
// Status word, read only:
//   bit 0 fault line level
//   bit 1 auto-zero pulse
//   bit 2 truncation flag, set by a positive event in any reaction, even brake or ignore
//   bit 3 resistor gain loaded
//   bits 6:4 gain in use
//   bits 10:7 consecutive cycle count
// Command word:
//   bit 0 written high clears a latched fault
// Hazards:
//   The bus answers one cycle after the request
//   A held strobe is not taken twice, ack blocks it
//   Sense outputs follow the PWM inputs one cycle late
//   Gate outputs are combinational from the PWM inputs
//   A fault set and a clear in one cycle keep the fault

// What this block does
// - Charge pump clock, four rates, 781.3k default
// - Spread spectrum on by default, can disable
// - Optional pre-charge before driver enable
// - Each sense amplifier enabled on its own
// - Offset select, half supply by default
// - Auto-zero after high-side edge timeout
// - Auto-zero continuous in standby, can disable
// - User calibration with gates low
// - Gain four after reset, seven others
// - Sample external gain resistor once at start
// - Always-off mode disables amplifier outputs
// - Low-side window, OR for single shunt
// - Extended window includes both dead-times
// - Always-on mode connects enabled outputs
// - Leading-edge blanking, zero or 50ns-8us
// - Shared positive and negative thresholds
// - Positive overcurrent truncates all high sides
// - Reactions: report, truncate only, ignore
// - Optional braking instead of truncation
// - Latched fault held until clear command
// - Fault after N consecutive PWM cycles
module gdsc_core #(
	parameter int AZ_TIMEOUT = `GDSC_AZ_TIMEOUT_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire gdsc_pkg::gdsc_gates_t pwm_i,
	input wire logic driver_stage_enable_i,
	input wire logic standby_i,
	input wire logic [6:0] external_gain_resistor_i,
	input wire logic [2:0] oc_pos_i,
	input wire logic [2:0] oc_neg_i,
	output gdsc_pkg::gdsc_gates_t gate_out_o,
	output logic pump_clk_o,
	output logic pump_precharge_o,
	output logic [2:0] sense_amp_output_o,
	output logic [2:0] sense_in_connect_o,
	output logic [2:0] amp_enable_o,
	output logic [2:0] gain_code_o,
	output logic [1:0] offset_code_o,
	output logic auto_zero_o,
	output logic calibrate_o,
	output logic brake_o,
	output logic fault_line_n_o
);

	// Elaboration check on the timeout
	if (AZ_TIMEOUT < 2 || AZ_TIMEOUT > 131071) begin : g_bad
		$error("AZ_TIMEOUT out of range");
	end

	// ****************************************
	// Functions
	// ****************************************
	// Blanking length in cycles from the 3-bit code
	function automatic logic [12:0] blank_len(input logic [2:0] code);
		unique case (code)
			3'h0: blank_len = 13'h0000;
			3'h1: blank_len = 13'(`GDSC_BLANK_MIN_CYC);
			3'h2: blank_len = 13'(`GDSC_BLANK_MID1_CYC);
			3'h3: blank_len = 13'(`GDSC_BLANK_MID2_CYC);
			3'h4: blank_len = 13'(`GDSC_BLANK_MID3_CYC);
			3'h5: blank_len = 13'(`GDSC_BLANK_MID4_CYC);
			3'h6: blank_len = 13'(`GDSC_BLANK_MID5_CYC);
			3'h7: blank_len = 13'(`GDSC_BLANK_MAX_CYC);
		endcase
	endfunction

	// Next blank count: reload on transition, else count down
	function automatic logic [12:0] blank_step(input logic edge_seen, input logic [12:0] cnt,
		input logic [2:0] code);
		if (edge_seen) begin
			blank_step = blank_len(code);
		end else if (cnt != 13'h0000) begin
			blank_step = cnt - 13'h0001;
		end else begin
			blank_step = cnt;
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	gdsc_pkg::gdsc_state_t s_q; // Registered state
	gdsc_pkg::gdsc_state_t s_d; // Next state
	gdsc_pkg::gdsc_mode_t mode; // Sense window mode
	gdsc_pkg::gdsc_react_t react; // Overcurrent reaction
	logic wb_req; // Bus request present this cycle
	logic [31:0] wmask; // Byte lane mask
	logic [2:0] en; // Amplifier enables
	logic [2:0] win; // Raw sense windows
	logic [2:0] blank; // Blanking active per phase
	logic [2:0] oc_pos_v; // Unblanked positive comparators
	logic oc_any; // Any valid overcurrent
	logic pwm_start; // Start of a PWM cycle: any high-side rising
	logic [3:0] oc_target; // Consecutive count target
	logic [8:0] pump_div; // Pump half period in cycles, with spread
	logic [2:0] blank_code; // Blanking code
	logic clear_cmd; // Clear command write
	logic truncate; // High sides forced off

	// ****************************************
	// Decoded controls
	// ****************************************
	always_comb begin
		mode = gdsc_pkg::gdsc_mode_t'(s_q.sense_q[`GDSC_SNS_MODE_LO +: 2]);
		react = gdsc_pkg::gdsc_react_t'(s_q.ocp_q[`GDSC_OCP_REACT_LO +: 2]);
		en = s_q.sense_q[`GDSC_SNS_EN_LO +: 3];
		blank_code = s_q.sense_q[`GDSC_SNS_BLANK_LO +: 3];
		oc_target = s_q.ocp_q[`GDSC_OCP_COUNT_LO +: 4];
		wb_req = wb_cyc_i && wb_stb_i && !s_q.ack_q;
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		clear_cmd = wb_req && wb_we_i && wb_adr_i == `GDSC_OFS_CMD && wb_sel_i[0]
			&& wb_dat_i[`GDSC_CMD_CLEAR];
		// Blanking on phase p: its blank counter not yet at zero
		blank = 3'h0;
		for (int p = 0; p < 3; p++) begin
			blank[p] = s_q.blank_cnt_q0 != 13'h0000 && p == 0
				|| s_q.blank_cnt_q1 != 13'h0000 && p == 1
				|| s_q.blank_cnt_q2 != 13'h0000 && p == 2;
		end
		// Sense window per phase
		unique case (mode)
			gdsc_pkg::GDSC_MODE_OFF: win = 3'h0;
			gdsc_pkg::GDSC_MODE_LOWSIDE: win = pwm_i.low;
			gdsc_pkg::GDSC_MODE_EXTENDED: win = ~pwm_i.high;
			gdsc_pkg::GDSC_MODE_ON: win = 3'h7;
		endcase
		// Single shunt uses the OR of all low-side windows
		if (mode == gdsc_pkg::GDSC_MODE_LOWSIDE && en == 3'h1) begin
			win = {2'b00, |pwm_i.low};
		end
		oc_pos_v = oc_pos_i & ~blank & en;
		oc_any = |oc_pos_v || |(oc_neg_i & ~blank & en);
		pwm_start = |(pwm_i.high & ~s_q.hs_prev_q);
		// Half period per rate code; code 3 is the slowest, code 2 the fastest
		pump_div = 9'(`GDSC_PUMP_DIV_781K);
		unique case (s_q.pump_q[`GDSC_PUMP_FREQ_LO +: 2])
			2'h0: pump_div = 9'(`GDSC_PUMP_DIV_781K);
			2'h1: pump_div = 9'(`GDSC_PUMP_DIV_781K * 2);
			2'h2: pump_div = 9'(`GDSC_PUMP_DIV_781K / 2);
			2'h3: pump_div = 9'(`GDSC_PUMP_DIV_781K * 4);
		endcase
		// Spread only lengthens half periods, so the clock never runs fast
		if (s_q.pump_q[`GDSC_PUMP_SPREAD]) begin
			pump_div = pump_div + {5'h00, s_q.lfsr_q};
		end
		truncate = s_q.trunc_q && react != gdsc_pkg::GDSC_REACT_IGNORE
			&& react != gdsc_pkg::GDSC_REACT_BRAKE;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		// Bus slave: one wait-free ack per request
		s_d.ack_q = wb_req;
		if (wb_req && !wb_we_i) begin
			unique case (wb_adr_i)
				`GDSC_OFS_PUMP: s_d.rdata_q = s_q.pump_q;
				`GDSC_OFS_SENSE: s_d.rdata_q = s_q.sense_q;
				`GDSC_OFS_OCP: s_d.rdata_q = s_q.ocp_q;
				`GDSC_OFS_STATUS: s_d.rdata_q = {21'h0, s_q.oc_run_q, s_q.gain_q,
					s_q.gain_loaded_q, s_q.trunc_q, s_q.az_pulse_q, !s_q.fault_q};
				default: s_d.rdata_q = 32'h0000_0000;
			endcase
		end
		if (wb_req && wb_we_i) begin
			if (wb_adr_i == `GDSC_OFS_PUMP) begin
				s_d.pump_q = (s_q.pump_q & ~wmask) | (wb_dat_i & wmask);
			end
			if (wb_adr_i == `GDSC_OFS_SENSE) begin
				s_d.sense_q = (s_q.sense_q & ~wmask) | (wb_dat_i & wmask);
			end
			if (wb_adr_i == `GDSC_OFS_OCP) begin
				s_d.ocp_q = (s_q.ocp_q & ~wmask) | (wb_dat_i & wmask);
			end
		end
		// Charge pump clock divider
		// Toggle after pump_div cycles, counter running 0 to pump_div - 1
		if (s_q.pump_cnt_q >= pump_div - 9'h001) begin
			s_d.pump_cnt_q = 9'h000;
			s_d.pump_clk_q = !s_q.pump_clk_q;
			s_d.lfsr_q = {s_q.lfsr_q[2:0], s_q.lfsr_q[3] ^ s_q.lfsr_q[2]};
		end else begin
			s_d.pump_cnt_q = s_q.pump_cnt_q + 9'h001;
		end
		// Blanking restarts at every gate transition of a phase
		s_d.hs_prev_q = pwm_i.high;
		s_d.ls_prev_q = pwm_i.low;
		s_d.blank_cnt_q0 = blank_step(pwm_i.high[0] != s_q.hs_prev_q[0]
			|| pwm_i.low[0] != s_q.ls_prev_q[0], s_q.blank_cnt_q0, blank_code);
		s_d.blank_cnt_q1 = blank_step(pwm_i.high[1] != s_q.hs_prev_q[1]
			|| pwm_i.low[1] != s_q.ls_prev_q[1], s_q.blank_cnt_q1, blank_code);
		s_d.blank_cnt_q2 = blank_step(pwm_i.high[2] != s_q.hs_prev_q[2]
			|| pwm_i.low[2] != s_q.ls_prev_q[2], s_q.blank_cnt_q2, blank_code);
		s_d.win_prev_q = win;
		s_d.sense_conn_q = win & en;
		// Auto-zero watchdog
		s_d.az_pulse_q = 1'b0;
		if (s_q.sense_q[`GDSC_SNS_AZ_DIS]) begin
			s_d.az_cnt_q = 17'h0;
		end else if (standby_i) begin
			s_d.az_pulse_q = 1'b1;
			s_d.az_cnt_q = 17'h0;
		end else if (pwm_start) begin
			s_d.az_cnt_q = 17'h0;
		end else if (s_q.az_cnt_q >= 17'(AZ_TIMEOUT - 1)) begin
			s_d.az_cnt_q = 17'h0;
			s_d.az_pulse_q = 1'b1;
		end else begin
			s_d.az_cnt_q = s_q.az_cnt_q + 17'h1;
		end
		// Gain: resistor sampled once on first driver enable
		if (!s_q.sense_q[`GDSC_SNS_GAINSRC]) begin
			s_d.gain_q = s_q.sense_q[`GDSC_SNS_GAIN_LO +: 3];
		end else if (!s_q.gain_loaded_q && driver_stage_enable_i) begin
			s_d.gain_q = external_gain_resistor_i[6:4];
			s_d.gain_loaded_q = 1'b1;
		end
		// Overcurrent: count PWM cycles holding an event
		if (oc_any && react != gdsc_pkg::GDSC_REACT_IGNORE) begin
			s_d.oc_in_cycle_q = 1'b1;
		end
		if (pwm_start) begin
			s_d.oc_in_cycle_q = 1'b0;
			if (s_q.oc_in_cycle_q) begin
				s_d.oc_run_q = (s_q.oc_run_q == 4'hf) ? s_q.oc_run_q : s_q.oc_run_q + 4'h1;
			end else begin
				s_d.oc_run_q = 4'h0;
			end
		end
		s_d.trunc_q = |oc_pos_v || (s_q.trunc_q && !pwm_start);
		// Fault line: set wins over clear
		if (!s_q.ocp_q[`GDSC_OCP_LATCH]) begin
			s_d.fault_q = 1'b0;
		end else if (clear_cmd) begin
			s_d.fault_q = 1'b0;
		end
		if (react == gdsc_pkg::GDSC_REACT_TRUNC_REPORT && oc_any
			&& {1'b0, s_q.oc_run_q} + 5'h01 >= {1'b0, oc_target}) begin
			// Five bits so a saturated count cannot wrap past the target
			s_d.fault_q = 1'b1;
		end
		if (!s_q.gain_loaded_q && !s_q.sense_q[`GDSC_SNS_GAINSRC]) begin
			s_d.gain_loaded_q = 1'b0;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.pump_q <= `GDSC_RST_PUMP;
			s_q.sense_q <= `GDSC_RST_SENSE;
			s_q.ocp_q <= `GDSC_RST_OCP;
			s_q.lfsr_q <= 4'h1;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb begin
		wb_ack_o = s_q.ack_q;
		wb_dat_o = s_q.rdata_q;
		// Truncation forces all high sides off; braking turns all low sides on in brake mode 1, all off in modes 2 and 3
		gate_out_o.high = truncate ? 3'h0 : pwm_i.high;
		gate_out_o.low = pwm_i.low;
		brake_o = s_q.trunc_q && react == gdsc_pkg::GDSC_REACT_BRAKE;
		if (brake_o && s_q.ocp_q[`GDSC_OCP_BRAKE_LO +: 2] != 2'h0) begin
			gate_out_o.high = 3'h0;
			gate_out_o.low = (s_q.ocp_q[`GDSC_OCP_BRAKE_LO +: 2] == 2'h1) ? 3'h7 : 3'h0;
		end
		pump_clk_o = s_q.pump_clk_q;
		pump_precharge_o = s_q.pump_q[`GDSC_PUMP_PRECHG] && !driver_stage_enable_i;
		sense_amp_output_o = s_q.sense_conn_q;
		sense_in_connect_o = s_q.sense_conn_q & ~blank;
		amp_enable_o = (mode == gdsc_pkg::GDSC_MODE_OFF) ? 3'h0 : en;
		gain_code_o = s_q.gain_q;
		offset_code_o = s_q.sense_q[`GDSC_SNS_OFS_LO +: 2];
		auto_zero_o = s_q.az_pulse_q;
		calibrate_o = s_q.sense_q[`GDSC_SNS_CAL] && pwm_i == '0;
		fault_line_n_o = !s_q.fault_q;
	end

endmodule

// File: testbench/gdsc_props.sv
// Port checks of the sense and overcurrent control block.
`timescale 1ns/1ps
module gdsc_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire gdsc_pkg::gdsc_gates_t pwm_i,
	input wire logic driver_stage_enable_i,
	input wire gdsc_pkg::gdsc_gates_t gate_out_o,
	input wire logic pump_clk_o,
	input wire logic pump_precharge_o,
	input wire logic [2:0] sense_amp_output_o,
	input wire logic [2:0] sense_in_connect_o,
	input wire logic [2:0] amp_enable_o,
	input wire logic [2:0] gain_code_o,
	input wire logic [1:0] offset_code_o,
	input wire logic brake_o,
	input wire logic fault_line_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic pump_prev_q; // Pump clock one cycle ago
	logic [9:0] still_q; // Cycles since the pump clock last moved
	// ****
	// Pump activity counter
	// ****
	// Spread spectrum stretches half periods, so the bound leaves room
	always_ff @(posedge clk_i) begin
		pump_prev_q <= pump_clk_o;
		still_q <= (rst_i || pump_clk_o != pump_prev_q) ? 10'h000 : still_q + 10'h001;
	end
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_precharge_idle: assert property (pump_precharge_o |-> !driver_stage_enable_i)
		else $error("precharge while driver enabled");
	a_blank_subset: assert property ((sense_in_connect_o & ~sense_amp_output_o) == 3'h0)
		else $error("input connected while output is not");
	a_conn_enabled: assert property ((sense_amp_output_o & ~$past(amp_enable_o)) == 3'h0)
		else $error("disabled amplifier connected");
	a_high_gated: assert property (!brake_o |-> (gate_out_o.high & ~pwm_i.high) == 3'h0)
		else $error("high side on without its input");
	a_reset_gain: assert property ($fell(rst_i) |-> gain_code_o == 3'h0 && offset_code_o == 2'h0)
		else $error("gain or offset not at default");
	a_reset_fault: assert property ($fell(rst_i) |-> fault_line_n_o)
		else $error("fault line low after reset");
	a_pump_running: assert property (still_q < 10'h258)
		else $error("pump clock stopped");
	cover property (!fault_line_n_o);
	cover property (brake_o);
	cover property (sense_in_connect_o != sense_amp_output_o);
endmodule
bind gdsc_core gdsc_props chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pwm_i,
	.driver_stage_enable_i, .gate_out_o, .pump_clk_o, .pump_precharge_o, .sense_amp_output_o,
	.sense_in_connect_o, .amp_enable_o, .gain_code_o, .offset_code_o, .brake_o, .fault_line_n_o);

// File: testbench/gdsc_mcu_model.sv
// Microcontroller PWM source: one switching phase, one phase held low.
`timescale 1ns/1ps
module gdsc_mcu_model #(
	parameter int PERIOD = 40,
	parameter int ON = 15,
	parameter int DEAD = 3
) (
	input wire logic clk_i,
	input wire logic run_i,
	output gdsc_pkg::gdsc_gates_t pwm_o
);
	int cnt_q; // Position in the PWM period
	// Period counter, held at zero while stopped
	always_ff @(posedge clk_i) begin
		cnt_q <= (!run_i || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
	end
	// Dead time on both edges keeps the phase free of shoot-through
	always_comb begin
		pwm_o = '0;
		if (run_i) begin
			pwm_o.high[0] = cnt_q < ON;
			pwm_o.low[0] = cnt_q >= ON + DEAD && cnt_q < PERIOD - DEAD;
			pwm_o.low[1] = 1'b1;
		end
	end
endmodule

// File: testbench/tb.sv
// Self-checking bench of the sense and overcurrent control block.
`timescale 1ns/1ps
`include "gdsc_params.svh"
module tb;
	// Sense window case: enables, mode, PWM and expected connection
	typedef struct packed {
		logic [2:0] en;
		logic [1:0] mode;
		logic [5:0] pwm;
		logic [2:0] conn;
	} gdsc_row_t;
	gdsc_row_t rows [7] = '{{3'h7, 2'h0, 6'h07, 3'h0}, {3'h7, 2'h1, 6'h05, 3'h5},
		{3'h7, 2'h1, 6'h38, 3'h0}, {3'h1, 2'h1, 6'h04, 3'h1}, {3'h7, 2'h2, 6'h08, 3'h6},
		{3'h7, 2'h3, 6'h38, 3'h7}, {3'h2, 2'h3, 6'h00, 3'h2}};
	int per [4] = '{160, 320, 80, 640}; // Pump period in cycles per rate code
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat, rd;
	logic wb_ack, pump_clk, prechg, az, cal, brake, fault_n;
	logic run = 1'b0; // PWM source running
	logic use_model = 1'b0; // PWM from the partner, not the table
	logic drv_en = 1'b0;
	logic standby = 1'b0;
	logic [2:0] oc_pos = 3'h0;
	logic [2:0] oc_neg = 3'h0;
	logic [2:0] sns_out, sns_in, amp_en, gain;
	logic [1:0] ofs;
	gdsc_pkg::gdsc_gates_t tb_pwm = '0;
	gdsc_pkg::gdsc_gates_t mcu_pwm, gate_out;
	int err_total = 0;
	int cmp_count = 0;
	int n;
	time t0;
	always #4 clk_i = ~clk_i;
	gdsc_mcu_model mcu_u (.clk_i(clk_i), .run_i(run), .pwm_o(mcu_pwm));
	gdsc_core #(.AZ_TIMEOUT(50)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
		.wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.pwm_i(use_model ? mcu_pwm : tb_pwm), .driver_stage_enable_i(drv_en),
		.standby_i(standby), .external_gain_resistor_i(7'h00), .oc_pos_i(oc_pos),
		.oc_neg_i(oc_neg), .gate_out_o(gate_out), .pump_clk_o(pump_clk),
		.pump_precharge_o(prechg), .sense_amp_output_o(sns_out), .sense_in_connect_o(sns_in),
		.amp_enable_o(amp_en), .gain_code_o(gain), .offset_code_o(ofs), .auto_zero_o(az),
		.calibrate_o(cal), .brake_o(brake), .fault_line_n_o(fault_n));
	// ****
	// Tasks
	// ****
	// Classic cycle held until ack; data taken at the ack edge only
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int k;
		k = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wdat <= dat;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack !== 1'b1 && k < 20);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
		if (k >= 20) check(1'b0, 1'b1, "bus timeout");
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// Counts cycles with auto-zero high over a span
	task automatic az_count(input int span);
		n = 0;
		repeat (span) begin
			@(posedge clk_i);
			if (az === 1'b1) n++;
		end
	endtask
	task automatic hs_wait(input int k);
		repeat (k) @(posedge mcu_pwm.high[0]);
		@(posedge clk_i);
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog well past the expected run length
	initial begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		complete_run();
	end
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(0, `GDSC_OFS_PUMP, 0);
		check(rd, 32'h4, "pump reset");
		bus(0, `GDSC_OFS_SENSE, 0);
		check(rd[12:3], 10'h001, "sense reset");
		bus(0, `GDSC_OFS_OCP, 0);
		check(rd, 32'h20, "ocp reset");
		bus(1, 8'h14, 32'hffff_ffff);
		bus(0, 8'h14, 0);
		check(rd, 32'h0, "unmapped");
		$display("reset test done");
		foreach (rows[i]) begin
			bus(1, `GDSC_OFS_SENSE, {27'h0, rows[i].mode, rows[i].en});
			tb_pwm <= rows[i].pwm;
			repeat (3) @(posedge clk_i);
			check(sns_out, rows[i].conn, "window");
			check(sns_in, rows[i].conn, "unblanked");
		end
		$display("window table done");
		// Shortest blanking on phase 0 only
		bus(1, `GDSC_OFS_SENSE, 32'h41f);
		tb_pwm <= 6'h01;
		repeat (3) @(posedge clk_i);
		check(sns_in, 3'h6, "blank start");
		repeat (10) @(posedge clk_i);
		check(sns_in, 3'h7, "blank end");
		for (int g = 0; g < 8; g++) begin
			bus(1, `GDSC_OFS_SENSE, {22'h0, g[1:0], g[2:0], 5'h0f});
			repeat (2) @(posedge clk_i);
			check(gain, g[2:0], "gain");
			check(ofs, g[1:0], "offset");
		end
		tb_pwm <= '0;
		bus(1, `GDSC_OFS_SENSE, 32'h1000f);
		check(cal, 1'b1, "calibrate");
		$display("blank gain test done");
		// Spread off so each period is exact
		for (int f = 0; f < 4; f++) begin
			bus(1, `GDSC_OFS_PUMP, f);
			repeat (2) @(posedge pump_clk);
			t0 = $time;
			@(posedge pump_clk);
			check(32'(($time - t0) / 8), per[f], "pump period");
			@(posedge clk_i);
		end
		bus(1, `GDSC_OFS_PUMP, 32'h8);
		check(prechg, 1'b1, "precharge");
		drv_en <= 1'b1;
		@(posedge clk_i);
		check(prechg, 1'b0, "precharge end");
		$display("pump test done");
		use_model <= 1'b1;
		bus(1, `GDSC_OFS_SENSE, 32'h0f);
		az_count(120);
		check(n > 0, 1'b1, "auto-zero idle");
		run <= 1'b1;
		repeat (10) @(posedge clk_i);
		az_count(300);
		check(n, 0, "auto-zero switching");
		standby <= 1'b1;
		repeat (5) @(posedge clk_i);
		check(az, 1'b1, "standby");
		standby <= 1'b0;
		bus(1, `GDSC_OFS_SENSE, 32'h400f);
		az_count(150);
		check(n, 0, "auto-zero off");
		$display("auto-zero test done");
		for (int r = 0; r < 4; r++) begin
			bus(1, `GDSC_OFS_OCP, 32'h20 | r);
			oc_pos <= 3'h1;
			hs_wait(2);
			repeat (3) @(posedge clk_i);
			check(fault_n, r != 0, "report");
			check(brake, r == 2, "brake");
			if (r != 2) check(gate_out.high, r == 3, "truncation");
			oc_pos <= 3'h0;
			hs_wait(2);
			check(fault_n, 1'b1, "release");
		end
		bus(1, `GDSC_OFS_OCP, 32'h70);
		oc_pos <= 3'h1;
		hs_wait(1);
		check(fault_n, 1'b1, "count early");
		hs_wait(3);
		check(fault_n, 1'b0, "count reached");
		oc_pos <= 3'h0;
		hs_wait(3);
		check(fault_n, 1'b0, "latched");
		bus(1, `GDSC_OFS_CMD, 32'h1);
		repeat (2) @(posedge clk_i);
		check(fault_n, 1'b1, "cleared");
		bus(1, `GDSC_OFS_OCP, 32'h20);
		oc_neg <= 3'h1;
		repeat (3) @(posedge clk_i);
		check(fault_n, 1'b0, "negative report");
		oc_neg <= 3'h0;
		repeat (3) @(posedge clk_i);
		check(fault_n, 1'b1, "negative release");
		$display("overcurrent test done");
		complete_run();
	end
endmodule
